// file: rtl/port_command_params.svh
// Offsets, field positions, reset values and opcodes of the command decoder
`ifndef PORT_COMMAND_PARAMS_SVH
`define PORT_COMMAND_PARAMS_SVH

`define PORT_COMMAND_OFFSET      8'h23
`define PORT_COMMAND_RESET       8'h00
`define WAKE_HOST_IF_OP          8'h11
`define PRESENCE_DETECT_OFF_OP   8'h22
`define PRESENCE_DETECT_ON_OP    8'h33
`define SINK_PATH_OFF_OP         8'h44
`define SINK_PATH_ON_OP          8'h55
`define SOURCE_PATH_OFF_OP       8'h66
`define SOURCE_DEFAULT_LEVEL_OP  8'h77
`define SOURCE_HIGH_LEVEL_OP     8'h88
`define SEEK_CONNECTION_OP       8'h99
`define RECEIVE_LAST_PACKET_OP   8'haa
`define HOST_IF_IDLE_OP          8'hff
`define CC_TERM_RP               2'h1
`define CC_TERM_RD               2'h2
`define ERROR_FLAG_BIT           0

`endif

// file: rtl/port_command_pkg.sv
// Types shared by the command decoder
package port_command_pkg;

  // Power path state kept by the decoder
  typedef struct packed {
    logic presence_detect;
    logic sink_on;
    logic source_on;
    logic source_high;
  } power_ctrl_t;

  // One-cycle action pulses toward neighbouring blocks
  typedef struct packed {
    logic wake_host_if;
    logic host_if_idle;
    logic seek_connection;
    logic start_with_rp;
    logic receive_last_packet;
  } action_pulse_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_EXECUTE,
    ST_CLEAR
  } decode_state_t;

endpackage : port_command_pkg

// file: rtl/port_command_decoder.sv
// Command register and opcode decoder of the Type-C port controller
`timescale 1ns/1ps
`default_nettype none
`include "port_command_params.svh"

// Function
// - Command register at 0x23, resets to zero, auto-clears after acting.
// - Wake opcode only pulses host interface wake.
// - Detect-off opcode turns presence detection off.
// - Detect-off while sourcing or sinking is ignored and flags error.
// - Detect-on opcode turns presence detection on.
// - Sink-off opcode turns sink path off, detection untouched.
// - Sink-on opcode turns sink path and detection on.
// - Sink-on while sourcing is ignored and flags error.
// - Source-off opcode turns source path off, detection untouched.
// - Default source opcode sources 5 V, detection on, leaves high level.
// - Default source while sinking is ignored and flags error.
// - High source opcode selects high-voltage path unless rejected.
// - Seek opcode starts dual-role toggling only if dual-role bit set.
// - Toggling starts with Rp for both 01b, Rd for both 10b.
// - Other termination field pairs never start toggling.
// - Last-packet opcode arms receiver stop after next GoodCRC.
// - Idle opcode puts the host interface into idle.
// - High source rejected unless sourcing 5 V, not sinking, capable.
// - Error flag latched until software writes one to its bit.
module port_command_decoder
  import port_command_pkg::*;
(
  input  wire logic                          clock,
  input  wire logic                          sys_rst,
  input  wire logic                          reg_write,
  input  wire logic                          reg_read,
  input  wire logic [7:0]                    reg_addr,
  input  wire logic [7:0]                    reg_wdata,
  input  wire logic                          error_clear_write,
  input  wire logic [7:0]                    error_clear_data,
  input  wire logic                          dual_role_enable_bit,
  input  wire logic [1:0]                    cc1_termination_field,
  input  wire logic [1:0]                    cc2_termination_field,
  input  wire logic                          high_level_capable,
  output logic      [7:0]                    reg_rdata,
  output port_command_pkg::power_ctrl_t      power_ctrl,
  output port_command_pkg::action_pulse_t    action_pulse,
  output logic                               host_command_error_flag
);
  import port_command_pkg::*;

  decode_state_t state_q, state_d;
  logic [7:0]    command_q, command_d;
  power_ctrl_t   power_q, power_d;
  action_pulse_t pulse_q, pulse_d;
  logic          error_q, error_d;
  logic [7:0]    rdata_q, rdata_d;
  logic          reject;
  logic          hit;
  logic          toggle_ok;
  logic          error_wr_clear;

  assign hit = (reg_addr == `PORT_COMMAND_OFFSET);
  // Both fields must agree on one termination
  assign toggle_ok = dual_role_enable_bit &&
                     (cc1_termination_field == cc2_termination_field) &&
                     ((cc1_termination_field == `CC_TERM_RP) ||
                      (cc1_termination_field == `CC_TERM_RD));
  assign error_wr_clear = error_clear_write &&
                          error_clear_data[`ERROR_FLAG_BIT];

  // Rejection conditions per opcode, from present power state
  always_comb
  begin
    reject = 1'b0;
    case (command_q)
      // Refuse while any power path is live
      `PRESENCE_DETECT_OFF_OP: reject = power_q.sink_on || power_q.source_on;
      `SINK_PATH_ON_OP:        reject = power_q.source_on;
      `SOURCE_DEFAULT_LEVEL_OP: reject = power_q.sink_on;
      // High level needs 5 V sourcing, no sink, capability
      `SOURCE_HIGH_LEVEL_OP:   reject = !power_q.source_on ||
                                        power_q.source_high ||
                                        power_q.sink_on ||
                                        !high_level_capable;
      default:                 reject = 1'b0;
    endcase
  end

  // Next-state logic of register, power state, pulses and error flag
  always_comb
  begin
    state_d   = state_q;
    command_d = command_q;
    power_d   = power_q;
    pulse_d   = '0;
    error_d   = error_q;
    rdata_d   = rdata_q;
    if (reg_read)
    begin
      rdata_d = hit ? command_q : 8'h00;
    end
    // Clear by writing one; a same-cycle fault below wins
    if (error_wr_clear)
    begin
      error_d = 1'b0;
    end
    case (state_q)
      ST_IDLE:
      begin
        // Only a write to the command offset loads an opcode
        if (reg_write && hit)
        begin
          command_d = reg_wdata;
          state_d   = ST_EXECUTE;
        end
      end
      ST_EXECUTE:
      begin
        state_d = ST_CLEAR;
        if (reject)
        begin
          // Rejected opcodes only raise the fault
          error_d = 1'b1;
        end
        else
        begin
          case (command_q)
            `WAKE_HOST_IF_OP:        pulse_d.wake_host_if = 1'b1;
            `PRESENCE_DETECT_OFF_OP: power_d.presence_detect = 1'b0;
            `PRESENCE_DETECT_ON_OP:  power_d.presence_detect = 1'b1;
            `SINK_PATH_OFF_OP:       power_d.sink_on = 1'b0;
            `SINK_PATH_ON_OP:
            begin
              power_d.sink_on         = 1'b1;
              power_d.presence_detect = 1'b1;
            end
            // Source off drops high level too
            `SOURCE_PATH_OFF_OP:
            begin
              power_d.source_on   = 1'b0;
              power_d.source_high = 1'b0;
            end
            // 5 V source, detection on, back from high level
            `SOURCE_DEFAULT_LEVEL_OP:
            begin
              power_d.source_on       = 1'b1;
              power_d.source_high     = 1'b0;
              power_d.presence_detect = 1'b1;
            end
            `SOURCE_HIGH_LEVEL_OP:   power_d.source_high = 1'b1;
            // Toggling start gated by dual-role bit
            `SEEK_CONNECTION_OP:
            begin
              pulse_d.seek_connection = toggle_ok;
              pulse_d.start_with_rp   = toggle_ok &&
                (cc1_termination_field == `CC_TERM_RP);
            end
            // Arm receiver stop after next GoodCRC
            `RECEIVE_LAST_PACKET_OP: pulse_d.receive_last_packet = 1'b1;
            `HOST_IF_IDLE_OP:        pulse_d.host_if_idle = 1'b1;
            // Reserved and unassigned values do nothing
            default:                 pulse_d = '0;
          endcase
        end
      end
      ST_CLEAR:
      begin
        command_d = `PORT_COMMAND_RESET;
        state_d   = ST_IDLE;
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // Registers only; everything settles to off after reset
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      state_q   <= ST_IDLE;
      command_q <= `PORT_COMMAND_RESET;
      power_q   <= '0;
      pulse_q   <= '0;
      error_q   <= 1'b0;
      rdata_q   <= 8'h00;
    end
    else
    begin
      state_q   <= state_d;
      command_q <= command_d;
      power_q   <= power_d;
      pulse_q   <= pulse_d;
      error_q   <= error_d;
      rdata_q   <= rdata_d;
    end
  end

  assign reg_rdata               = rdata_q;
  assign power_ctrl              = power_q;
  assign action_pulse            = pulse_q;
  assign host_command_error_flag = error_q;

  // Executing a command always returns the register to zero two edges on
  sequence s_load;
    reg_write && hit && state_q == ST_IDLE;
  endsequence

  // Execute, clear, then idle again with the register back at zero
  sequence s_execute_clear;
    state_q == ST_EXECUTE ##1 state_q == ST_CLEAR
    ##1 state_q == ST_IDLE && command_q == `PORT_COMMAND_RESET;
  endsequence

  a_command_auto_clear:
    assert property (@(posedge clock) disable iff (sys_rst)
      s_load |=> s_execute_clear)
    else $error("command register did not auto-clear");

  a_detect_off_reject:
    assert property (@(posedge clock) disable iff (sys_rst)
      state_q == ST_EXECUTE && command_q == `PRESENCE_DETECT_OFF_OP &&
      (power_q.sink_on || power_q.source_on)
      |=> error_q && power_q.presence_detect == $past(power_q.presence_detect))
    else $error("detect-off not refused while powered");

  a_sink_on_effect:
    assert property (@(posedge clock) disable iff (sys_rst)
      state_q == ST_EXECUTE && command_q == `SINK_PATH_ON_OP &&
      !power_q.source_on |=> power_q.sink_on && power_q.presence_detect)
    else $error("sink-on did not enable sink and detection");

  a_sink_on_reject:
    assert property (@(posedge clock) disable iff (sys_rst)
      state_q == ST_EXECUTE && command_q == `SINK_PATH_ON_OP &&
      power_q.source_on |=> error_q && !power_q.sink_on)
    else $error("sink-on not refused while sourcing");

  a_default_source:
    assert property (@(posedge clock) disable iff (sys_rst)
      state_q == ST_EXECUTE && command_q == `SOURCE_DEFAULT_LEVEL_OP &&
      !power_q.sink_on
      |=> power_q.source_on && !power_q.source_high && power_q.presence_detect)
    else $error("default source level not applied");

  a_high_reject:
    assert property (@(posedge clock) disable iff (sys_rst)
      state_q == ST_EXECUTE && command_q == `SOURCE_HIGH_LEVEL_OP &&
      (!power_q.source_on || !high_level_capable)
      |=> error_q && !power_q.source_high)
    else $error("high level not refused");

  a_toggle_gate:
    assert property (@(posedge clock) disable iff (sys_rst)
      action_pulse.seek_connection |-> $past(toggle_ok))
    else $error("toggling started with bad role control");

  a_error_sticky:
    assert property (@(posedge clock) disable iff (sys_rst)
      error_q && !error_wr_clear |=> error_q)
    else $error("error flag dropped without a clear");

  a_command_load:
    assert property (@(posedge clock) disable iff (sys_rst)
      s_load |=> command_q == $past(reg_wdata))
    else $error("command register did not load the opcode");

  a_wake_only:
    assert property (@(posedge clock) disable iff (sys_rst)
      state_q == ST_EXECUTE && command_q == `WAKE_HOST_IF_OP
      |=> action_pulse.wake_host_if && power_q == $past(power_q))
    else $error("wake opcode changed more than the wake pulse");

  a_detect_off_effect:
    assert property (@(posedge clock) disable iff (sys_rst)
      state_q == ST_EXECUTE && command_q == `PRESENCE_DETECT_OFF_OP &&
      !power_q.sink_on && !power_q.source_on |=> !power_q.presence_detect)
    else $error("detect-off did not turn detection off");

  a_sink_off_effect:
    assert property (@(posedge clock) disable iff (sys_rst)
      state_q == ST_EXECUTE && command_q == `SINK_PATH_OFF_OP
      |=> !power_q.sink_on &&
      power_q.presence_detect == $past(power_q.presence_detect))
    else $error("sink-off did not leave detection alone");

  a_source_off_effect:
    assert property (@(posedge clock) disable iff (sys_rst)
      state_q == ST_EXECUTE && command_q == `SOURCE_PATH_OFF_OP
      |=> !power_q.source_on && !power_q.source_high &&
      power_q.presence_detect == $past(power_q.presence_detect))
    else $error("source-off did not leave detection alone");

  a_high_effect:
    assert property (@(posedge clock) disable iff (sys_rst)
      state_q == ST_EXECUTE && command_q == `SOURCE_HIGH_LEVEL_OP &&
      power_q.source_on && !power_q.source_high && !power_q.sink_on &&
      high_level_capable |=> power_q.source_high && power_q.source_on)
    else $error("high level not applied");

  a_seek_start:
    assert property (@(posedge clock) disable iff (sys_rst)
      state_q == ST_EXECUTE && command_q == `SEEK_CONNECTION_OP &&
      dual_role_enable_bit && cc1_termination_field == cc2_termination_field &&
      (cc1_termination_field == `CC_TERM_RP ||
       cc1_termination_field == `CC_TERM_RD)
      |=> action_pulse.seek_connection &&
      action_pulse.start_with_rp ==
      ($past(cc1_termination_field) == `CC_TERM_RP))
    else $error("toggling did not start with the chosen termination");

  a_last_packet:
    assert property (@(posedge clock) disable iff (sys_rst)
      state_q == ST_EXECUTE && command_q == `RECEIVE_LAST_PACKET_OP
      |=> action_pulse.receive_last_packet)
    else $error("last-packet arm pulse missing");

  a_reserved_quiet:
    assert property (@(posedge clock) disable iff (sys_rst)
      state_q == ST_EXECUTE && command_q inside {8'hcc, 8'hdd, 8'hee}
      |=> action_pulse == '0 && power_q == $past(power_q))
    else $error("reserved opcode had an effect");

endmodule : port_command_decoder
`default_nettype wire

// file: test/port_manager_model.sv
// Port manager model issuing register writes, reads and error clears
`timescale 1ns/1ps
`default_nettype none
module port_manager_model
(
  input  wire logic       clock,
  output var  logic       reg_write,
  output var  logic       reg_read,
  output var  logic [7:0] reg_addr,
  output var  logic [7:0] reg_wdata,
  output var  logic       error_clear_write,
  output var  logic [7:0] error_clear_data
);
  // Idle bus at time zero
  initial
  begin
    {reg_write, reg_read, error_clear_write} = 3'h0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    error_clear_data = 8'h00;
  end

  // One-cycle strobe: 0 write, 1 read, 2 error clear
  // Data inverted after release so stale values never look valid
  task automatic req(input int k, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_write <= (k == 0);
    reg_read <= (k == 1);
    error_clear_write <= (k == 2);
    reg_addr <= a;
    reg_wdata <= d;
    error_clear_data <= d;
    @(posedge clock);
    {reg_write, reg_read, error_clear_write} <= 3'h0;
    reg_wdata <= ~d;
    error_clear_data <= ~d;
  endtask : req
endmodule : port_manager_model
`default_nettype wire

// file: test/port_command_decoder_tb.sv
// Self-checking bench of the command decoder against a behavioural model
`timescale 1ns/1ps
`default_nettype none
`include "port_command_params.svh"
module port_command_decoder_tb;
  import port_command_pkg::*;
  logic          clock, sys_rst, reg_write, reg_read, error_clear_write;
  logic [7:0]    reg_addr, reg_wdata, error_clear_data, reg_rdata, op;
  logic          drp, cap, err_flag;
  logic [1:0]    cc1, cc2;
  logic [31:0]   lfsr;
  power_ctrl_t   pc;
  action_pulse_t ap;
  int            errors, n_compared, cycles, pd, snk, src, hi, er;
  // seek listed twice, drawn with fresh role control each time
  logic [7:0] ops [16] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66,
    8'h77, 8'h88, 8'h99, 8'h99, 8'haa, 8'hcc, 8'hdd, 8'hee, 8'hff, 8'h00};

  port_command_decoder port_command_decoder_i (.clock(clock),
    .sys_rst(sys_rst), .reg_write(reg_write), .reg_read(reg_read),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .error_clear_write(error_clear_write),
    .error_clear_data(error_clear_data), .dual_role_enable_bit(drp),
    .cc1_termination_field(cc1), .cc2_termination_field(cc2),
    .high_level_capable(cap), .reg_rdata(reg_rdata), .power_ctrl(pc),
    .action_pulse(ap), .host_command_error_flag(err_flag));

  port_manager_model port_manager_model_i (.clock(clock),
    .reg_write(reg_write), .reg_read(reg_read), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .error_clear_write(error_clear_write),
    .error_clear_data(error_clear_data));

  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_of_test

  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : next_rand

  // Model: p = {wake, idle, seek, last packet, start with Rp}
  task automatic model(input logic [7:0] c, output logic [4:0] p);
    p = 5'h0;
    case (c)
      `WAKE_HOST_IF_OP: p[4] = 1'b1;
      `PRESENCE_DETECT_OFF_OP:
        if (snk | src)
          er = 1;
        else
          pd = 0;
      `PRESENCE_DETECT_ON_OP: pd = 1;
      `SINK_PATH_OFF_OP: snk = 0;
      `SINK_PATH_ON_OP:
        if (src)
          er = 1;
        else
        begin
          snk = 1;
          pd = 1;
        end
      `SOURCE_PATH_OFF_OP:
      begin
        src = 0;
        hi = 0;
      end
      `SOURCE_DEFAULT_LEVEL_OP:
        if (snk)
          er = 1;
        else
        begin
          src = 1;
          pd = 1;
          hi = 0;
        end
      `SOURCE_HIGH_LEVEL_OP:
        if (src && !hi && !snk && cap)
          hi = 1;
        else
          er = 1;
      `SEEK_CONNECTION_OP:
        if (drp && cc1 == cc2 && (cc1 == `CC_TERM_RP || cc1 == `CC_TERM_RD))
          p[2:0] = {1'b1, 1'b0, cc1 == `CC_TERM_RP};
      `RECEIVE_LAST_PACKET_OP: p[1] = 1'b1;
      `HOST_IF_IDLE_OP: p[3] = 1'b1;
      default: p = 5'h0;
    endcase
  endtask : model

  // Write, compare effects while the pulses stand, then read back
  task automatic cmd(input logic [7:0] a, input logic [7:0] c);
    logic [4:0] p;
    p = 5'h0;
    port_manager_model_i.req(0, a, c);
    if (a == `PORT_COMMAND_OFFSET)
      model(c, p);
    // Pulses stand one cycle, one edge after the write is taken
    @(posedge clock);
    #1;
    // Power levels also
    check({4'h0, pc}, {4'h0, pd[0], snk[0], src[0], hi[0]});
    check({3'h0, ap.wake_host_if, ap.host_if_idle, ap.seek_connection,
      ap.receive_last_packet, ap.seek_connection & ap.start_with_rp},
      {3'h0, p});
    check({7'h0, err_flag}, {7'h0, er[0]});
    port_manager_model_i.req(1, `PORT_COMMAND_OFFSET, 8'h00);
    #1;
    check(reg_rdata, `PORT_COMMAND_RESET); // auto clear
  endtask : cmd

  // Cycle ceiling cuts a hang short
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      $display("[ERR] %0t run too long", $time);
      end_of_test();
    end
  end

  initial
  begin
    {sys_rst, drp, cap, cc1, cc2} = 7'h40;
    {errors, n_compared, cycles, pd, snk, src, hi, er} = '0;
    lfsr = 32'hc47d;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    #1;
    check({3'h0, pc, err_flag}, 8'h00); // reset state
    port_manager_model_i.req(1, `PORT_COMMAND_OFFSET, 8'h00);
    #1;
    check(reg_rdata, `PORT_COMMAND_RESET); // reset value
    $display("test reset done");
    // seek reissued with role control left unchanged
    @(posedge clock);
    drp <= 1'b1;
    cc1 <= `CC_TERM_RD;
    cc2 <= `CC_TERM_RD;
    cmd(`PORT_COMMAND_OFFSET, `SEEK_CONNECTION_OP); // first seek
    cmd(`PORT_COMMAND_OFFSET, `SEEK_CONNECTION_OP); // same role
    $display("test seek repeat done");
    for (int i = 0; i < 600; i++)
    begin
      lfsr = next_rand(lfsr);
      @(posedge clock);
      drp <= lfsr[8] | lfsr[9];
      cap <= lfsr[15] | lfsr[16];
      cc1 <= lfsr[11:10];
      cc2 <= lfsr[12] ? lfsr[11:10] : lfsr[14:13];
      op = (lfsr[4] & lfsr[7]) ? lfsr[31:24] : ops[lfsr[3:0]];
      if (lfsr[7:5] == 3'h0)
      begin
        port_manager_model_i.req(2, 8'h00, lfsr[23:16]);
        if (lfsr[16])
          er = 0;
        @(posedge clock);
        #1;
        check({7'h0, err_flag}, {7'h0, er[0]}); // write one clears
      end
      else
        cmd((lfsr[7:5] == 3'h1) ? 8'h24 : `PORT_COMMAND_OFFSET, op);
    end
    $display("test random commands done");
    end_of_test();
  end
endmodule : port_command_decoder_tb
`default_nettype wire
